// >>> common/msst_pkg.sv
`default_nettype none
`include "msst_regs.svh"
package msst_pkg;
   typedef struct packed {
      logic                     valid;
      logic                     sof;
      logic                     sol;
      logic [`MSST_PIX_W-1:0]   data;
   } msst_pix_t;

   typedef struct packed {
      logic [`MSST_MN_W-1:0]    m;
      logic [`MSST_MN_W-1:0]    n;
   } msst_mn_t;

   typedef struct packed {
      logic [`MSST_TW-1:0]      h_act;
      logic [`MSST_OVL_W-1:0]   ovl;
      logic [`MSST_TW-1:0]      v_act;
      logic [`MSST_TW-1:0]      v_blank;
      logic [`MSST_TW-1:0]      h_blank;
      logic [`MSST_TW-1:0]      h_fp;
   } msst_timing_t;

   typedef struct packed {
      logic                     upd;
      logic [`MSST_TW-1:0]      first;
      logic [`MSST_TW-1:0]      last;
   } msst_su_t;
endpackage : msst_pkg
`default_nettype wire

// >>> common/msst_regs.svh
`ifndef MSST_REGS_SVH
`define MSST_REGS_SVH
// ----------------------------------------
// widths
// ----------------------------------------
`define MSST_AW         8
`define MSST_DW         32
`define MSST_LANES      4
`define MSST_PIX_W      24
`define MSST_MN_W       24
`define MSST_TW         13
`define MSST_OVL_W      8
`define MSST_FRM_W      16
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MSST_OFS_CTRL   8'h00
`define MSST_OFS_HTIM   8'h04
`define MSST_OFS_VTIM   8'h08
`define MSST_OFS_BLANK  8'h0C
`define MSST_OFS_LINKM  8'h10
`define MSST_OFS_LINKN  8'h14
`define MSST_OFS_SU     8'h18
`define MSST_OFS_STAT   8'h1C
// ----------------------------------------
// control fields
// ----------------------------------------
`define MSST_C_SEGMODE  0
`define MSST_C_PORTEN   1
`define MSST_C_LANES4   2
`define MSST_C_ASSR     3
`define MSST_C_DSC      4
`define MSST_C_TRAIN    5
`define MSST_C_PSR      6
`define MSST_C_DEEP     7
`define MSST_C_WAKE     8
`define MSST_C_SUGO     9
// upper field of a two-field register
`define MSST_HI_LSB     16
// ----------------------------------------
// status fields
// ----------------------------------------
`define MSST_S_RUN      0
`define MSST_S_SLEEP    1
`define MSST_S_GTCFRM   2
`define MSST_S_MNPEND   3
`define MSST_S_LANE_LSB 4
`define MSST_S_HPD      8
`define MSST_S_FRM_LSB  16
// ----------------------------------------
// lane groups, reset, timing
// ----------------------------------------
`define MSST_LANES_2X1  4'h3
`define MSST_LANES_2X2  4'hF
`define MSST_RST_WORD   32'h0000_0000
`define MSST_GTC_MS     10
`define MSST_CLK_KHZ    25000
`endif

// >>> design/msst_sync.sv
`timescale 1ns/1ps
`default_nettype none
module msst_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] lvl,
   output logic      [WIDTH-1:0] rise
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
      logic [WIDTH-1:0] rise;
   } msst_sync_st_t;

   msst_sync_st_t st_ff;
   msst_sync_st_t nxt_st;

   if (WIDTH < 1) begin : g_chk
      $error("msst_sync: WIDTH must be at least 1");
   end

   // ----------------------------------------
   // three stages; level moves only when stages two and three agree
   // ----------------------------------------
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.s1   = d;
      nxt_st.s2   = st_ff.s1;
      nxt_st.s3   = st_ff.s2;
      nxt_st.lvl  = (st_ff.s2 & st_ff.s3) | (st_ff.lvl & (st_ff.s2 | st_ff.s3));
      nxt_st.rise = nxt_st.lvl & ~st_ff.lvl;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign lvl  = st_ff.lvl;
   assign rise = st_ff.rise;
endmodule : msst_sync
`default_nettype wire

// >>> design/msst_tx.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "msst_regs.svh"
`default_nettype none
// Notes on behaviour
// - each panel segment gets its own stream on its own lane group of one port
// - two segments: 2x1 on lanes 0,1 or 2x2 on lanes 0 to 3
// - stream attributes per segment: 2x2 on lanes 0,1 repeated 2,3; 2x1 lane 0 and 1
// - one programmed timing set drives every segment
// - training takes all enabled lanes together as one link
// - refresh switching keeps segments aligned; new M/N reaches all lanes at once
// - scrambler seed reset is on for all segments or none
// - time code update goes from 10 ms to per frame in deep sleep
// - all segments enter and leave self refresh sleep together
// - selective update refreshes same blocks on every segment
// - power management frame syncs are common to all segments
// - one fast wake request wakes every segment link
// - with compression the same parameter set goes to every segment
// - segments are enabled only as a whole group
// - one pipe only; no YUV formats in segmented mode
// - one aux channel and one hot plug line for the whole panel
// - writing link N arms new M/N, applied from the next frame
module msst_tx #(
   parameter int SEGS       = 2,
   parameter int GTC_CYCLES = `MSST_GTC_MS * `MSST_CLK_KHZ
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic [`MSST_AW-1:0]    addr,
   input  wire logic [`MSST_DW-1:0]    wdata,
   input  wire logic                   wr_stb,
   input  wire logic                   rd_stb,
   output logic      [`MSST_DW-1:0]    rdata,
   input  wire msst_pkg::msst_pix_t    pix_in,
   input  wire logic                   link_symbol_clock,
   input  wire logic                   hpd_pin,
   output msst_pkg::msst_pix_t [SEGS-1:0] seg_pix,
   output msst_pkg::msst_timing_t      seg_timing,
   output msst_pkg::msst_mn_t          mn_live,
   output msst_pkg::msst_su_t          su_out,
   output logic      [`MSST_LANES-1:0] lane_en,
   output logic      [`MSST_LANES-1:0] lane_msa,
   output logic      [`MSST_LANES-1:0] lane_pps,
   output logic      [`MSST_LANES-1:0] lane_assr,
   output logic      [`MSST_LANES-1:0] train_lanes,
   output logic                        train_req,
   output logic                        frame_sync,
   output logic                        gtc_pulse,
   output logic                        panel_sleep,
   output logic                        fast_wake
);
   import msst_pkg::*;

   localparam int L  = `MSST_LANES;
   localparam int TW = `MSST_TW;
   localparam int CW = `MSST_TW + 1;
   localparam int GW = $clog2(GTC_CYCLES + 1);
   localparam logic [GW-1:0] GTC_LAST = GW'(GTC_CYCLES - 1);

   if (SEGS != 2 || GTC_CYCLES < 2) begin : g_chk
      $error("msst_tx: needs SEGS of 2 and GTC_CYCLES of 2 or more");
   end

   typedef struct packed {
      logic                  seg_mode;
      logic                  port_en;
      logic                  lanes4;
      logic                  assr;
      logic                  dsc;
      logic                  psr_en;
      logic                  deep_req;
      msst_timing_t          tim;
      logic [`MSST_MN_W-1:0] m_sh;
      logic [`MSST_MN_W-1:0] n_sh;
      logic                  mn_pend;
      msst_mn_t              mn;
      logic [TW-1:0]         su_first;
      logic [TW-1:0]         su_last;
      logic                  su_pend;
      msst_su_t              su;
      logic [CW-1:0]         col;
      msst_pix_t [SEGS-1:0]  seg;
      logic                  asleep;
      logic                  msa_pend;
      logic                  pps_pend;
      logic                  train_req;
      logic                  frame_sync;
      logic                  gtc_pulse;
      logic                  fast_wake;
      logic [L-1:0]          lane_en;
      logic [L-1:0]          lane_msa;
      logic [L-1:0]          lane_pps;
      logic [L-1:0]          lane_assr;
      logic [L-1:0]          train_lanes;
      logic [GW-1:0]         gtc_cnt;
      logic [`MSST_FRM_W-1:0] frames;
      logic [`MSST_DW-1:0]   rdata;
   } msst_tx_st_t;

   msst_tx_st_t st_ff;
   msst_tx_st_t nxt_st;

   // ----------------------------------------
   // pin inputs
   // ----------------------------------------
   logic lk_rise;
   logic hpd_lvl;

   msst_sync #(.WIDTH(1)) u_lk_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (link_symbol_clock),
      .lvl     (),
      .rise    (lk_rise)
   );

   msst_sync #(.WIDTH(1)) u_hpd_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (hpd_pin),
      .lvl     (hpd_lvl),
      .rise    ()
   );

   // ----------------------------------------
   // decode and segment windows
   // ----------------------------------------
   logic          run;
   logic          sof_evt;
   logic          ctrl_wr;
   logic          linkn_wr;
   logic          wake_wr;
   logic          sugo_wr;
   logic          gtc_frm;
   logic [CW-1:0] cur_col;
   logic [CW-1:0] hx;
   logic [CW-1:0] ovx;
   logic [CW-1:0] lo_a [SEGS];
   logic [SEGS-1:0] in_win;

   // port runs only once segmented mode is set
   assign run      = st_ff.seg_mode & st_ff.port_en;
   assign sof_evt  = run & pix_in.valid & pix_in.sof;
   assign ctrl_wr  = wr_stb && (addr == `MSST_OFS_CTRL);
   assign linkn_wr = wr_stb && (addr == `MSST_OFS_LINKN);
   assign wake_wr  = ctrl_wr & wdata[`MSST_C_WAKE];
   assign sugo_wr  = ctrl_wr & wdata[`MSST_C_SUGO];
   assign gtc_frm  = st_ff.asleep & st_ff.deep_req;
   assign cur_col  = pix_in.sol ? '0 : st_ff.col;
   assign hx       = {1'b0, st_ff.tim.h_act};
   assign ovx      = {{(CW - `MSST_OVL_W){1'b0}}, st_ff.tim.ovl};

   // even width keeps slices aligned, not checked here
   for (genvar s = 0; s < SEGS; s++) begin : g_win
      localparam logic [CW-1:0] SI = CW'(s);
      localparam logic [CW-1:0] SN = CW'(s + 1);
      logic [CW-1:0] hi;
      assign lo_a[s]   = (s == 0) ? '0 : CW'(SI * hx - ovx);
      assign hi        = (s == SEGS - 1) ? CW'(SN * hx) : CW'(SN * hx + ovx);
      assign in_win[s] = (cur_col >= lo_a[s]) && (cur_col < hi);
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_st            = st_ff;
      nxt_st.rdata      = `MSST_RST_WORD;
      nxt_st.lane_msa   = '0;
      nxt_st.lane_pps   = '0;
      nxt_st.train_req  = 1'b0;
      nxt_st.frame_sync = 1'b0;
      nxt_st.gtc_pulse  = 1'b0;
      nxt_st.fast_wake  = 1'b0;
      nxt_st.su.upd     = 1'b0;

      if (wr_stb) begin
         case (addr)
            `MSST_OFS_CTRL: begin
               nxt_st.seg_mode = wdata[`MSST_C_SEGMODE];
               nxt_st.port_en  = wdata[`MSST_C_PORTEN];
               nxt_st.lanes4   = wdata[`MSST_C_LANES4];
               nxt_st.assr     = wdata[`MSST_C_ASSR];
               nxt_st.dsc      = wdata[`MSST_C_DSC];
               nxt_st.psr_en   = wdata[`MSST_C_PSR];
               nxt_st.deep_req = wdata[`MSST_C_DEEP];
            end
            `MSST_OFS_HTIM: begin
               nxt_st.tim.h_act = wdata[TW-1:0];
               nxt_st.tim.ovl   = wdata[`MSST_HI_LSB +: `MSST_OVL_W];
            end
            `MSST_OFS_VTIM: begin
               nxt_st.tim.v_act   = wdata[TW-1:0];
               nxt_st.tim.v_blank = wdata[`MSST_HI_LSB +: TW];
            end
            `MSST_OFS_BLANK: begin
               nxt_st.tim.h_blank = wdata[TW-1:0];
               nxt_st.tim.h_fp    = wdata[`MSST_HI_LSB +: TW];
            end
            `MSST_OFS_LINKM: nxt_st.m_sh = wdata[`MSST_MN_W-1:0];
            `MSST_OFS_LINKN: nxt_st.n_sh = wdata[`MSST_MN_W-1:0];
            `MSST_OFS_SU: begin
               nxt_st.su_first = wdata[TW-1:0];
               nxt_st.su_last  = wdata[`MSST_HI_LSB +: TW];
            end
            default: ;
         endcase
      end

      if (nxt_st.seg_mode && nxt_st.port_en) begin
         nxt_st.lane_en = nxt_st.lanes4 ? `MSST_LANES_2X2 : `MSST_LANES_2X1;
      end else begin
         nxt_st.lane_en = '0;
      end
      nxt_st.lane_assr = nxt_st.assr ? nxt_st.lane_en : '0;

      if (ctrl_wr && wdata[`MSST_C_TRAIN] && nxt_st.lane_en != '0) begin
         nxt_st.train_req   = 1'b1;
         nxt_st.train_lanes = nxt_st.lane_en;
      end

      for (int s = 0; s < SEGS; s++) begin
         nxt_st.seg[s].valid = run & pix_in.valid & in_win[s];
         nxt_st.seg[s].sof   = pix_in.sof;
         nxt_st.seg[s].sol   = (cur_col == lo_a[s]);
         nxt_st.seg[s].data  = pix_in.data;
      end
      if (run && pix_in.valid) begin
         nxt_st.col = CW'(cur_col + 1'b1);
      end

      // arm on link N, apply at frame start
      nxt_st.mn_pend = st_ff.mn_pend | linkn_wr;
      nxt_st.su_pend = st_ff.su_pend | sugo_wr;
      if (sof_evt) begin
         nxt_st.frame_sync = 1'b1;
         nxt_st.frames     = `MSST_FRM_W'(st_ff.frames + 1'b1);
         nxt_st.msa_pend   = 1'b1;
         nxt_st.pps_pend   = st_ff.dsc;
         if (st_ff.mn_pend) begin
            nxt_st.mn.m    = st_ff.m_sh;
            nxt_st.mn.n    = st_ff.n_sh;
            nxt_st.mn_pend = linkn_wr;
         end
         if (st_ff.su_pend) begin
            nxt_st.su.upd   = 1'b1;
            nxt_st.su.first = st_ff.su_first;
            nxt_st.su.last  = st_ff.su_last;
            nxt_st.su_pend  = sugo_wr;
         end
         // sleep is entered at frame start only; a wake write below leaves it in any cycle
         nxt_st.asleep = st_ff.psr_en;
      end

      if (wake_wr) begin
         nxt_st.fast_wake = 1'b1;
         nxt_st.asleep    = 1'b0;
      end

      // attribute packets leave on a link edge so all lanes start together
      if (lk_rise && st_ff.msa_pend) begin
         // new M/N on all lanes at once
         nxt_st.lane_msa = nxt_st.lane_en;
         // a frame start in this very cycle queues a fresh packet, set wins
         nxt_st.msa_pend = sof_evt;
         nxt_st.lane_pps = st_ff.pps_pend ? nxt_st.lane_en : '0;
         nxt_st.pps_pend = sof_evt & st_ff.dsc;
      end

      if (gtc_frm) begin
         nxt_st.gtc_cnt   = '0;
         nxt_st.gtc_pulse = sof_evt;
      end else if (st_ff.gtc_cnt == GTC_LAST) begin
         nxt_st.gtc_cnt   = '0;
         nxt_st.gtc_pulse = run;
      end else begin
         nxt_st.gtc_cnt = GW'(st_ff.gtc_cnt + 1'b1);
      end

      if (rd_stb) begin
         case (addr)
            `MSST_OFS_CTRL: begin
               nxt_st.rdata[`MSST_C_SEGMODE] = st_ff.seg_mode;
               nxt_st.rdata[`MSST_C_PORTEN]  = st_ff.port_en;
               nxt_st.rdata[`MSST_C_LANES4]  = st_ff.lanes4;
               nxt_st.rdata[`MSST_C_ASSR]    = st_ff.assr;
               nxt_st.rdata[`MSST_C_DSC]     = st_ff.dsc;
               nxt_st.rdata[`MSST_C_PSR]     = st_ff.psr_en;
               nxt_st.rdata[`MSST_C_DEEP]    = st_ff.deep_req;
            end
            `MSST_OFS_HTIM: begin
               nxt_st.rdata[TW-1:0]                        = st_ff.tim.h_act;
               nxt_st.rdata[`MSST_HI_LSB +: `MSST_OVL_W]   = st_ff.tim.ovl;
            end
            `MSST_OFS_VTIM: begin
               nxt_st.rdata[TW-1:0]                = st_ff.tim.v_act;
               nxt_st.rdata[`MSST_HI_LSB +: TW]    = st_ff.tim.v_blank;
            end
            `MSST_OFS_BLANK: begin
               nxt_st.rdata[TW-1:0]                = st_ff.tim.h_blank;
               nxt_st.rdata[`MSST_HI_LSB +: TW]    = st_ff.tim.h_fp;
            end
            `MSST_OFS_LINKM: nxt_st.rdata[`MSST_MN_W-1:0] = st_ff.m_sh;
            `MSST_OFS_LINKN: nxt_st.rdata[`MSST_MN_W-1:0] = st_ff.n_sh;
            `MSST_OFS_SU: begin
               nxt_st.rdata[TW-1:0]                = st_ff.su_first;
               nxt_st.rdata[`MSST_HI_LSB +: TW]    = st_ff.su_last;
            end
            `MSST_OFS_STAT: begin
               nxt_st.rdata[`MSST_S_RUN]                = run;
               nxt_st.rdata[`MSST_S_SLEEP]              = st_ff.asleep;
               nxt_st.rdata[`MSST_S_GTCFRM]             = gtc_frm;
               nxt_st.rdata[`MSST_S_MNPEND]             = st_ff.mn_pend;
               nxt_st.rdata[`MSST_S_LANE_LSB +: L]      = st_ff.lane_en;
               nxt_st.rdata[`MSST_S_HPD]                = hpd_lvl;
               nxt_st.rdata[`MSST_S_FRM_LSB +: `MSST_FRM_W] = st_ff.frames;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // one timing set for all
   assign seg_timing  = st_ff.tim;
   assign seg_pix     = st_ff.seg;
   assign mn_live     = st_ff.mn;
   assign su_out      = st_ff.su;
   assign lane_en     = st_ff.lane_en;
   assign lane_msa    = st_ff.lane_msa;
   assign lane_pps    = st_ff.lane_pps;
   assign lane_assr   = st_ff.lane_assr;
   assign train_lanes = st_ff.train_lanes;
   assign train_req   = st_ff.train_req;
   assign frame_sync  = st_ff.frame_sync;
   assign gtc_pulse   = st_ff.gtc_pulse;
   assign panel_sleep = st_ff.asleep;
   assign fast_wake   = st_ff.fast_wake;
   assign rdata       = st_ff.rdata;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_LANES_2X1: assert property (run && !st_ff.lanes4 |-> lane_en == `MSST_LANES_2X1)
      else $error("2x1 lane group wrong");
   AST_MSA_ALL: assert property (lane_msa != '0 |-> lane_msa == lane_en && $past(st_ff.msa_pend))
      else $error("attribute packet not on all lanes");
   AST_PPS_ALL: assert property (lane_pps != '0 |-> lane_pps == lane_msa)
      else $error("parameter set not on all lanes");
   AST_ASSR_GROUP: assert property (lane_assr == '0 || lane_assr == lane_en)
      else $error("seed reset split across segments");
   AST_TRAIN_ALL: assert property (train_req |-> train_lanes == lane_en && lane_en != '0)
      else $error("training not on all lanes");
   AST_MN_HOLD: assert property (!$past(sof_evt) |-> $stable(mn_live))
      else $error("M/N changed outside frame start");
   AST_MN_APPLY: assert property (sof_evt && st_ff.mn_pend |=>
         mn_live.m == $past(st_ff.m_sh) && mn_live.n == $past(st_ff.n_sh))
      else $error("armed M/N not applied");
   AST_SLEEP_SYNC: assert property ($changed(panel_sleep) |-> $past(sof_evt) || $past(wake_wr))
      else $error("sleep changed off frame");
   AST_WAKE: assert property (wake_wr |=> fast_wake && !panel_sleep)
      else $error("fast wake did not wake");
   AST_GTC_FRAME: assert property ($past(gtc_frm) && gtc_pulse |-> $past(sof_evt))
      else $error("time code off frame in deep sleep");
   AST_SEG_GROUP: assert property (!$past(run) |-> seg_pix[0].valid == 1'b0 && seg_pix[1].valid == 1'b0)
      else $error("segment active while group off");
endmodule : msst_tx
`default_nettype wire

// >>> testbench/msst_panel_model.sv
`timescale 1ns/1ps
`include "msst_regs.svh"
`default_nettype none
module msst_panel_model (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic [`MSST_LANES-1:0] lane_en,
   input  wire logic [`MSST_LANES-1:0] lane_msa,
   output logic                        hpd_pin,
   output logic                        skew_ff
);
   // ----------------------------------------
   // plug state
   // ----------------------------------------
   // one hot plug line
   assign hpd_pin = 1'b1;
   // ----------------------------------------
   // attribute packet arrival
   // ----------------------------------------
   // all lanes together
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         skew_ff <= 1'b0;
      end else if (lane_msa != '0 && lane_msa != lane_en) begin
         skew_ff <= 1'b1;
      end
   end
endmodule : msst_panel_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`include "msst_regs.svh"
`default_nettype none
module tb_top;
   import msst_pkg::*;
   logic                   clk_sys, rst, wr_stb, rd_stb, lsc, hpd_pin, skew, train_req, frame_sync;
   logic                   panel_sleep, fast_wake, gtc_pulse;
   logic [`MSST_AW-1:0]    addr;
   logic [`MSST_DW-1:0]    wdata, rdata;
   logic [3:0]             lane_en, lane_msa, lane_pps, lane_assr, train_lanes;
   msst_pix_t              pix_in;
   msst_pix_t [1:0]        seg_pix;
   msst_timing_t           seg_timing;
   msst_mn_t               mn_live;
   msst_su_t               su_out, su_seen;
   logic [7:0]             msa_seen;
   int                     gtc_seen, g0;
   int                     fails, n_tests;

   msst_tx #(.SEGS(2), .GTC_CYCLES(20)) u_dut (
      .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .pix_in(pix_in), .link_symbol_clock(lsc), .hpd_pin(hpd_pin), .seg_pix(seg_pix),
      .seg_timing(seg_timing), .mn_live(mn_live), .su_out(su_out), .lane_en(lane_en), .lane_msa(lane_msa),
      .lane_pps(lane_pps), .lane_assr(lane_assr), .train_lanes(train_lanes), .train_req(train_req),
      .frame_sync(frame_sync), .gtc_pulse(gtc_pulse), .panel_sleep(panel_sleep), .fast_wake(fast_wake));
   msst_panel_model u_panel (
      .clk_sys(clk_sys), .rst(rst), .lane_en(lane_en), .lane_msa(lane_msa), .hpd_pin(hpd_pin),
      .skew_ff(skew));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // link clock runs in its own phase
   initial begin
      lsc = 1'b0;
      #7;
      forever #160 lsc = ~lsc;
   end
   // one-cycle pulses are latched, the packet may leave while the frame is still running
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         msa_seen <= '0;
         su_seen  <= '0;
         gtc_seen <= 0;
      end else begin
         if (lane_msa != '0) msa_seen <= {lane_pps, lane_msa};
         if (su_out.upd) su_seen <= su_out;
         if (gtc_pulse) gtc_seen <= gtc_seen + 1;
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1;
      chk("rdata", exp, rdata);
   endtask : rd
   // one line of 8 columns: 4 per segment plus 2 overlap
   task automatic frame();
      for (int c = 0; c < 9; c++) begin
         @(posedge clk_sys);
         pix_in <= (c < 8) ? msst_pix_t'({1'b1, c == 0, c == 0, 24'(c + 16)}) : '0;
         if (c > 0) begin
            #1;
            chk("seg0 valid", 32'(c - 1 < 6), 32'(seg_pix[0].valid));
            chk("seg1 valid", 32'(c - 1 >= 2), 32'(seg_pix[1].valid));
            if (c - 1 >= 2) chk("seg1 data", 32'(c + 15), 32'(seg_pix[1].data));
            if (c == 1) chk("frame_sync", 32'h0000_0001, 32'(frame_sync));
         end
      end
   endtask : frame
   task automatic print_verdict();
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (3000) @(posedge clk_sys);
      fails++;
      print_verdict();
   end

   initial begin
      fails = 0;
      n_tests = 0;
      rst = 1'b1;
      addr = '0;
      wdata = '0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      pix_in = '0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      rd(8'h00, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      wr(8'h04, 32'h0002_0004); // 4 plus 2 overlap stays even
      chk("h_act", 32'h0000_0004, 32'(seg_timing.h_act));
      chk("ovl", 32'h0000_0002, 32'(seg_timing.ovl));
      // segmented mode set before the port comes up
      wr(8'h00, 32'h0000_0001);
      wr(8'h00, 32'h0000_0023);
      chk("train_req", 32'h0000_0001, 32'(train_req));
      chk("train 2x1", 32'h0000_0003, 32'(train_lanes));
      rd(8'h1C, 32'h0000_0131);
      wr(8'h00, 32'h0000_003F);
      chk("train 2x2", 32'h0000_000F, 32'(train_lanes));
      rd(8'h00, 32'h0000_001F);
      chk("lane_en", 32'h0000_000F, 32'(lane_en));
      chk("lane_assr", 32'h0000_000F, 32'(lane_assr));
      wr(8'h10, 32'h0000_0123);
      wr(8'h14, 32'h0000_0456);
      chk("m early", 32'h0000_0000, 32'(mn_live.m));
      frame();
      chk("m", 32'h0000_0123, 32'(mn_live.m));
      chk("n", 32'h0000_0456, 32'(mn_live.n));
      repeat (12) @(posedge clk_sys);
      #1;
      chk("lane_msa", 32'h0000_000F, 32'(msa_seen[3:0]));
      chk("lane_pps", 32'h0000_000F, 32'(msa_seen[7:4]));
      wr(8'h00, 32'h0000_005F);
      frame();
      chk("sleep", 32'h0000_0001, 32'(panel_sleep));
      wr(8'h18, 32'h0008_0004);
      wr(8'h00, 32'h0000_02DF);
      repeat (2) @(posedge clk_sys);
      #1;
      g0 = gtc_seen;
      repeat (45) @(posedge clk_sys);
      #1;
      chk("gtc deep", 32'(g0), 32'(gtc_seen));
      frame();
      chk("gtc frame", 32'(g0 + 1), 32'(gtc_seen));
      chk("su first", 32'h0000_0004, 32'(su_seen.first));
      chk("su last", 32'h0000_0008, 32'(su_seen.last));
      rd(8'h1C, 32'h0003_01F7);
      wr(8'h00, 32'h0000_015F);
      chk("fast_wake", 32'h0000_0001, 32'(fast_wake));
      chk("wake sleep", 32'h0000_0000, 32'(panel_sleep));
      wr(8'h00, 32'h0000_0000);
      rd(8'h1C, 32'h0003_0100);
      chk("skew", 32'h0000_0000, 32'(skew));
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
